/* File: rtl/bmf_ctrl.sv */
// boost mode entry, safety timer, fault handling and high-impedance control
// Behaviour
// - in 32-second mode, OTG pin or boost select bit enables boost
// - boost start-up passes through a timed soft-start phase
// - current-limit comparator ends each switching cycle early
// - light-load skip stops switching; mid-rail droop resumes it
// - boost entry starts the 32-second safety timer
// - watchdog kick restarts timer; the kick bit self-clears
// - timer expiry stops boost, sets fault status, pulses status pin
// - timer fault stays latched until reset or host clear
// - bus overvoltage stops switching, clears select bit, faults, pulses
// - after bus overvoltage, boost resumes only by rewrite or OTG
// - overload drives input switch linear; fault after 30 ms
// - overload fault stops boost until host clears the fault
// - battery out of range stops boost, clears select, faults, pulses
// - after battery recovers, restart needs rewrite or active OTG
// - status pin released in boost; one 128-us low pulse per fault, none for a fault while a pulse runs
// - high-impedance bit with OTG inactive enters high-impedance mode
// - crude 32-second timer runs in high-impedance while battery low
// - crude timer expiry enters 32-minute mode and stops the timer
// - in 32-minute mode bus undervoltage forces high-impedance
// - any fault moves boost into the charge-configure state
`timescale 1ns/1ps
module bmf_ctrl
  import bmf_pkg::*;
#(
  parameter longint unsigned SAFE_CYCLES = bmf_pkg::SAFE_CYC,
  parameter longint unsigned OVLD_CYCLES = bmf_pkg::OVLD_CYC
)(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // host control bits
  input  wire logic       boost_select_wr,
  input  wire logic       boost_select_val,
  input  wire logic       watchdog_kick_wr,
  input  wire logic       high_impedance_bit,
  input  wire logic       fault_clear,
  // pins and analog comparators
  input  wire logic       otg_pin,
  input  wire logic       bus_ov_cmp,
  input  wire logic       overload_cmp,
  input  wire logic       bat_over_cmp,
  input  wire logic       bat_min_cmp,
  input  wire logic       bat_low_cmp,
  input  wire logic       cur_limit_cmp,
  input  wire logic       light_load_cmp,
  input  wire logic       mid_rail_low_cmp,
  input  wire logic       bus_uvlo_cmp,
  // status to host
  output logic            boost_select_bit,
  output logic            watchdog_kick_bit,
  output logic [3:0]      fault_status,
  output logic            mode_32min,
  // power stage controls
  output logic            boost_active,
  output logic            soft_start,
  output logic            switch_en,
  output logic            input_switch_linear,
  output logic            high_impedance,
  output logic            charge_cfg,
  // open-drain status pin
  output logic            stat_out,
  output logic            stat_oe_n
);
  import bmf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [SYNC_N-1:0] s;
  logic otg_s, ovl_s;
  logic bus_ov_s, bat_bad_s, bat_low_s, ilim_s, light_s, mid_low_s, uvlo_s;

  bmf_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({otg_pin, overload_cmp, bus_ov_cmp,
                bat_over_cmp | bat_min_cmp, bat_low_cmp, cur_limit_cmp,
                light_load_cmp, mid_rail_low_cmp}),
    .sync_out (s)
  );
  assign otg_s     = s[7];
  assign ovl_s     = s[6];
  assign bus_ov_s  = s[5];
  assign bat_bad_s = s[4];
  assign bat_low_s = s[3];
  assign ilim_s    = s[2];
  assign light_s   = s[1];
  assign mid_low_s = s[0];

  // second bank for the undervoltage comparator
  logic uv1;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uv1    <= 1'b0;
      uvlo_s <= 1'b0;
    end else begin
      uv1    <= bus_uvlo_cmp;
      uvlo_s <= uv1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  bmf_state_t state, next_state;
  logic [TMR_W-1:0] safe_cnt;
  logic [TMR_W-1:0] ovl_cnt;
  logic [TMR_W-1:0] crude_cnt;
  logic [SS_W-1:0]  ss_cnt;
  logic [7:0]       ss_sub;
  logic             ovl_latched;
  logic             timer_exp, ovl_exp, crude_exp;
  logic             fault_ev;
  logic             hiz_now;
  logic             boost_req;
  logic             skipping;

  assign hiz_now   = (high_impedance_bit && !otg_s)
                   || (mode_32min && uvlo_s);
  assign boost_req = !mode_32min && (otg_s || boost_select_bit)
                   && !hiz_now && !ovl_latched;
  assign timer_exp = (safe_cnt == TMR_W'(SAFE_CYCLES - 1));
  assign ovl_exp   = (ovl_cnt == TMR_W'(OVLD_CYCLES));
  assign crude_exp = (crude_cnt == TMR_W'(SAFE_CYCLES - 1));
  assign fault_ev  = boost_active &&
                     (bus_ov_s || bat_bad_s || ovl_exp || timer_exp);

  ////////////////////////////////////////////////////////////////////////
  // boost state machine
  always_comb begin
    next_state = state;
    case (state)
      BMF_IDLE: begin
        if (boost_req)
          next_state = BMF_SOFT;
      end
      BMF_SOFT, BMF_RUN: begin
        if (fault_ev)
          next_state = BMF_CFG;
        else if (!boost_req)
          next_state = BMF_IDLE;
        else if (state == BMF_SOFT && ss_cnt == '1 && ss_sub == '1)
          next_state = BMF_RUN;
      end
      BMF_CFG: begin
        if (!bus_ov_s && !bat_bad_s && boost_req)
          next_state = BMF_SOFT;
        else if (!boost_req)
          next_state = BMF_IDLE;
      end
      default: next_state = BMF_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      state <= BMF_IDLE;
    else
      state <= next_state;
  end

  // soft-start ramp, stepped by a sub-counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state != BMF_SOFT) begin
      ss_cnt <= '0;
      ss_sub <= '0;
    end else begin
      ss_sub <= ss_sub + 8'h01;
      if (ss_sub == '1 && ss_cnt != '1)
        ss_cnt <= ss_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host bits: boost select and watchdog kick
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      boost_select_bit <= 1'b0;
    else if (fault_ev && (bus_ov_s || bat_bad_s || ovl_exp))
      boost_select_bit <= 1'b0;
    else if (boost_select_wr)
      boost_select_bit <= boost_select_val;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      watchdog_kick_bit <= 1'b0;
    else if (watchdog_kick_wr)
      watchdog_kick_bit <= 1'b1;
    else
      watchdog_kick_bit <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // safety timer, overload timer, crude timer
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !boost_active || watchdog_kick_bit)
      safe_cnt <= '0;
    else if (!timer_exp)
      safe_cnt <= safe_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !boost_active || !ovl_s)
      ovl_cnt <= '0;
    else if (!ovl_exp)
      ovl_cnt <= ovl_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      ovl_latched <= 1'b0;
    else if (fault_ev && ovl_exp)
      ovl_latched <= 1'b1;
    else if (fault_clear)
      ovl_latched <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !high_impedance || !bat_low_s || mode_32min)
      crude_cnt <= '0;
    else if (!crude_exp)
      crude_cnt <= crude_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      mode_32min <= 1'b0;
    else if (crude_exp && high_impedance && bat_low_s)
      mode_32min <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // fault status, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      fault_status <= FLT_NONE;
    else if (fault_ev) begin
      if (bus_ov_s)
        fault_status <= FLT_BUS_OV;
      else if (ovl_exp)
        fault_status <= FLT_OVLD;
      else if (bat_bad_s)
        fault_status <= FLT_BAT;
      else
        fault_status <= FLT_TIMER;
    end else if (fault_clear)
      fault_status <= FLT_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // power stage controls
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      skipping <= 1'b0;
    else if (!boost_active || mid_low_s)
      skipping <= 1'b0;
    else if (light_s)
      skipping <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      boost_active        <= 1'b0;
      soft_start          <= 1'b0;
      switch_en           <= 1'b0;
      input_switch_linear <= 1'b0;
      high_impedance      <= 1'b0;
      charge_cfg          <= 1'b0;
    end else begin
      boost_active <= (next_state == BMF_SOFT || next_state == BMF_RUN);
      soft_start   <= (next_state == BMF_SOFT);
      switch_en    <= (next_state == BMF_SOFT || next_state == BMF_RUN)
                      && !fault_ev && !ilim_s && !skipping;
      input_switch_linear <= boost_active && ovl_s && !fault_ev;
      high_impedance      <= hiz_now;
      charge_cfg          <= (next_state == BMF_CFG);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status pin pulse
  bmf_pulse u_pulse (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .trig      (fault_ev),
    .stat_out  (stat_out),
    .stat_oe_n (stat_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_kick_self_clear: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    watchdog_kick_bit |=> !watchdog_kick_bit || $past(watchdog_kick_wr))
    else $error("kick bit did not clear");
  a_fault_sets_cfg: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    fault_ev |=> charge_cfg && !boost_active)
    else $error("fault did not leave boost");
  a_busov_clears_sel: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (fault_ev && bus_ov_s) |=> !boost_select_bit
      && fault_status == FLT_BUS_OV)
    else $error("bus overvoltage not handled");
  a_bat_clears_sel: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (fault_ev && bat_bad_s) |=> !boost_select_bit && fault_status != FLT_NONE)
    else $error("battery fault not handled");
  a_pulse_low: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $fell(stat_oe_n) |-> !stat_oe_n [*8])
    else $error("status pulse too short");
  a_pulse_fault: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (fault_ev && stat_oe_n) |=> !stat_oe_n)
    else $error("fault gave no status pulse");
  a_ovl_block: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ovl_latched |-> ##1 (!boost_active || $past(fault_clear)))
    else $error("boost ran with overload latched");
  a_hiz_mode: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (high_impedance_bit && !otg_s) |=> high_impedance)
    else $error("high impedance not entered");
  a_min32_uvlo: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (mode_32min && uvlo_s) |=> high_impedance)
    else $error("undervoltage high impedance missing");
  a_ilim_cut: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ilim_s |=> !switch_en)
    else $error("current limit ignored");
  a_ovl_linear: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (boost_active && ovl_s && !fault_ev) |=> input_switch_linear)
    else $error("overload did not limit");
  a_timer_flt: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (fault_ev && timer_exp) |=> !boost_active && fault_status != FLT_NONE)
    else $error("timer expiry not handled");
  a_soft_first: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(boost_active) |-> soft_start)
    else $error("boost began without soft start");
  c_boost_run: cover property (@(posedge ref_clk) state == BMF_RUN);
  c_timer_flt: cover property (@(posedge ref_clk)
    fault_ev && timer_exp);
  c_ovl_flt: cover property (@(posedge ref_clk) fault_ev && ovl_exp);
  c_min32: cover property (@(posedge ref_clk) $rose(mode_32min));
  c_bat_flt: cover property (@(posedge ref_clk) fault_ev && bat_bad_s);
endmodule

/* File: rtl/bmf_pkg.sv */
// constants and types for the boost mode fault controller
package bmf_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SAFE_TMR_S  = 32;
  localparam int unsigned OVLD_MS     = 30;
  localparam int unsigned FPULSE_US   = 128;
  localparam int unsigned SOFT_US     = 100;
  localparam longint unsigned SAFE_CYC = longint'(CLK_HZ) * SAFE_TMR_S;
  localparam longint unsigned OVLD_CYC =
    (longint'(CLK_HZ) * OVLD_MS) / 1000;
  localparam int unsigned FPULSE_CYC = (CLK_HZ / 1_000_000) * FPULSE_US;
  localparam int unsigned SOFT_CYC   = (CLK_HZ / 1_000_000) * SOFT_US;
  localparam int unsigned TMR_W      = 32;
  localparam int unsigned PW_W       = 13;
  localparam int unsigned SS_W       = 4;
  localparam int unsigned SYNC_N     = 8;
  localparam logic [3:0]  FLT_NONE   = 4'h0;
  localparam logic [3:0]  FLT_BUS_OV = 4'h1;
  localparam logic [3:0]  FLT_OVLD   = 4'h2;
  localparam logic [3:0]  FLT_BAT    = 4'h3;
  localparam logic [3:0]  FLT_TIMER  = 4'h4;
  typedef enum logic [1:0] {
    BMF_IDLE  = 2'b00,
    BMF_SOFT  = 2'b01,
    BMF_RUN   = 2'b10,
    BMF_CFG   = 2'b11
  } bmf_state_t;
endpackage

/* File: rtl/bmf_pulse.sv */
// one-shot low pulse generator for the open-drain status pin
`timescale 1ns/1ps
module bmf_pulse
  import bmf_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // trigger and pin
  input  wire logic trig,
  output logic      stat_out,
  output logic      stat_oe_n
);
  logic [PW_W-1:0] cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt       <= '0;
      stat_oe_n <= 1'b1;
    end else if (trig && cnt == '0) begin
      cnt       <= PW_W'(FPULSE_CYC);
      stat_oe_n <= 1'b0;
    end else if (cnt != '0) begin
      cnt       <= cnt - 1'b1;
      stat_oe_n <= (cnt == PW_W'(1));
    end else begin
      stat_oe_n <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    stat_out <= 1'b0;
  end
endmodule

/* File: rtl/bmf_sync.sv */
// two-flop synchroniser bank for comparator inputs
`timescale 1ns/1ps
module bmf_sync
  import bmf_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // async in, synced out
  input  wire logic [SYNC_N-1:0] async_in,
  output logic      [SYNC_N-1:0] sync_out
);
  logic [SYNC_N-1:0] stage1;
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          stage1[g]   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          stage1[g]   <= async_in[g];
          sync_out[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule

/* File: tb/bmf_host.sv */
// host model writing the controller's control bits
`timescale 1ns/1ps
module bmf_host
#(
  parameter int KICK_GAP = 500
)(
  // clock
  input  wire logic ref_clk,
  // control bit writes
  output logic      boost_select_wr,
  output logic      boost_select_val,
  output logic      watchdog_kick_wr,
  output logic      high_impedance_bit,
  output logic      fault_clear
);
  logic kick_en = 1'h0;
  int   gap     = 0;

  initial begin
    boost_select_wr    = 1'h0;
    boost_select_val   = 1'h0;
    high_impedance_bit = 1'h0;
    fault_clear        = 1'h0;
  end

  // kicks well inside the safety interval while enabled
  always @(negedge ref_clk) begin
    gap              <= (gap == KICK_GAP) ? 0 : gap + 1;
    watchdog_kick_wr <= kick_en && (gap == KICK_GAP);
  end

  task automatic sel(input logic v);
    @(negedge ref_clk);
    boost_select_wr  = 1'h1;
    boost_select_val = v;
    @(negedge ref_clk);
    boost_select_wr  = 1'h0;
  endtask

  task automatic clr();
    @(negedge ref_clk);
    fault_clear = 1'h1;
    @(negedge ref_clk);
    fault_clear = 1'h0;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the boost mode fault controller
`timescale 1ns/1ps
module tb;
  import bmf_pkg::*;
  localparam longint unsigned SAFE_T = 2000;
  localparam longint unsigned OVLD_T = 100;
  localparam int              LIMIT  = 60000;
  logic       ref_clk, rst_n, otg_pin, bus_ov_cmp, overload_cmp;
  logic       bat_over_cmp, bat_min_cmp, bat_low_cmp, cur_limit_cmp;
  logic       light_load_cmp, mid_rail_low_cmp, bus_uvlo_cmp;
  logic       boost_select_wr, boost_select_val, watchdog_kick_wr;
  logic       high_impedance_bit, fault_clear, boost_select_bit;
  logic       watchdog_kick_bit, mode_32min, boost_active, soft_start;
  logic       switch_en, input_switch_linear, high_impedance;
  logic       charge_cfg, stat_out, stat_oe_n;
  logic [3:0] fault_status;
  int         n_errors, n_compared, cyc, i;

  bmf_host u_host (
    .ref_clk(ref_clk), .boost_select_wr(boost_select_wr),
    .boost_select_val(boost_select_val),
    .watchdog_kick_wr(watchdog_kick_wr),
    .high_impedance_bit(high_impedance_bit), .fault_clear(fault_clear));

  bmf_ctrl #(.SAFE_CYCLES(SAFE_T), .OVLD_CYCLES(OVLD_T)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .boost_select_wr(boost_select_wr),
    .boost_select_val(boost_select_val),
    .watchdog_kick_wr(watchdog_kick_wr),
    .high_impedance_bit(high_impedance_bit), .fault_clear(fault_clear),
    .otg_pin(otg_pin), .bus_ov_cmp(bus_ov_cmp),
    .overload_cmp(overload_cmp), .bat_over_cmp(bat_over_cmp),
    .bat_min_cmp(bat_min_cmp), .bat_low_cmp(bat_low_cmp),
    .cur_limit_cmp(cur_limit_cmp), .light_load_cmp(light_load_cmp),
    .mid_rail_low_cmp(mid_rail_low_cmp), .bus_uvlo_cmp(bus_uvlo_cmp),
    .boost_select_bit(boost_select_bit),
    .watchdog_kick_bit(watchdog_kick_bit), .fault_status(fault_status),
    .mode_32min(mode_32min), .boost_active(boost_active),
    .soft_start(soft_start), .switch_en(switch_en),
    .input_switch_linear(input_switch_linear),
    .high_impedance(high_impedance), .charge_cfg(charge_cfg),
    .stat_out(stat_out), .stat_oe_n(stat_oe_n));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return boost_active;
      1: return stat_oe_n;
      2: return mode_32min;
      default: return watchdog_kick_bit;
    endcase
  endfunction

  // bounded wait at falling edges for a watched output to reach v
  task automatic wait_on(input int k, input logic v, input int max);
    for (i = 0; i < max && sig(k) !== v; i++) @(negedge ref_clk);
  endtask

  task automatic conclude();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, otg_pin, bus_ov_cmp, overload_cmp, bat_over_cmp} = 5'h0;
    {bat_min_cmp, bat_low_cmp, cur_limit_cmp, light_load_cmp} = 4'h0;
    {mid_rail_low_cmp, bus_uvlo_cmp, cyc, n_errors, n_compared} = 0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'h1;
    check({boost_active, charge_cfg, fault_status, stat_oe_n}, 7'h01);
    check(stat_out, 1'h0);
    // host-written boost with periodic kicks
    u_host.kick_en = 1'h1;
    u_host.sel(1'h1);
    check(boost_select_bit, 1'h1);
    wait_on(0, 1'h1, 8);
    check({boost_active, soft_start}, 2'h3);
    wait_on(3, 1'h1, 600);
    check(watchdog_kick_bit, 1'h1);
    @(negedge ref_clk);
    check(watchdog_kick_bit, 1'h0);
    repeat (4200) @(negedge ref_clk);
    check({boost_active, soft_start, switch_en}, 3'h5);
    light_load_cmp = 1'h1;
    repeat (6) @(negedge ref_clk);
    check(switch_en, 1'h0);
    light_load_cmp = 1'h0;
    mid_rail_low_cmp = 1'h1;
    repeat (6) @(negedge ref_clk);
    check(switch_en, 1'h1);
    mid_rail_low_cmp = 1'h0;
    // current limit cuts switching while it stands
    cur_limit_cmp = 1'h1;
    repeat (4) @(negedge ref_clk);
    check(switch_en, 1'h0);
    cur_limit_cmp = 1'h0;
    repeat (4) @(negedge ref_clk);
    check(switch_en, 1'h1);
    // bus overvoltage fault and its pulse
    bus_ov_cmp = 1'h1;
    wait_on(1, 1'h0, 8);
    check({boost_active, boost_select_bit, charge_cfg, fault_status},
          7'h11);
    for (i = 0; i < 6000 && stat_oe_n === 1'h0; i++) @(negedge ref_clk);
    check(i, FPULSE_CYC);
    bus_ov_cmp = 1'h0;
    repeat (10) @(negedge ref_clk);
    check(boost_active, 1'h0);
    u_host.clr();
    check(fault_status, 4'h0);
    u_host.sel(1'h1);
    wait_on(0, 1'h1, 8);
    check(boost_active, 1'h1);
    // overload: linear limiting, then latched fault
    overload_cmp = 1'h1;
    repeat (20) @(negedge ref_clk);
    check({input_switch_linear, fault_status}, 5'h10);
    for (i = 20; i < 300 && stat_oe_n !== 1'h0; i++) @(negedge ref_clk);
    check(i > OVLD_T, 1'h1);
    check({boost_active, boost_select_bit, fault_status}, 6'h02);
    overload_cmp = 1'h0;
    u_host.sel(1'h1);
    repeat (10) @(negedge ref_clk);
    check(boost_active, 1'h0);
    wait_on(1, 1'h1, 6000);
    u_host.clr();
    u_host.sel(1'h1);
    wait_on(0, 1'h1, 8);
    check(boost_active, 1'h1);
    // battery faults with the pin request still held
    otg_pin = 1'h1;
    u_host.sel(1'h0);
    bat_min_cmp = 1'h1;
    wait_on(1, 1'h0, 12);
    check({boost_active, boost_select_bit, fault_status}, 6'h03);
    bat_min_cmp = 1'h0;
    wait_on(0, 1'h1, 20);
    check(boost_active, 1'h1);
    bat_over_cmp = 1'h1;
    repeat (4) @(negedge ref_clk);
    check({boost_active, charge_cfg, fault_status}, 6'h13);
    bat_over_cmp = 1'h0;
    wait_on(0, 1'h1, 20);
    check(boost_active, 1'h1);
    wait_on(1, 1'h1, 6000);
    u_host.clr();
    // safety timer expiry without kicks
    u_host.kick_en = 1'h0;
    wait_on(1, 1'h0, 2600);
    otg_pin = 1'h0;
    check({charge_cfg, fault_status}, 5'h14);
    repeat (100) @(negedge ref_clk);
    check(fault_status, 4'h4);
    wait_on(1, 1'h1, 6000);
    u_host.clr();
    check(fault_status, 4'h0);
    // high-impedance entry, crude timer, long mode
    u_host.high_impedance_bit = 1'h1;
    repeat (2200) @(negedge ref_clk);
    check({high_impedance, mode_32min}, 2'h2);
    otg_pin = 1'h1;
    repeat (6) @(negedge ref_clk);
    check(high_impedance, 1'h0);
    otg_pin = 1'h0;
    bat_low_cmp = 1'h1;
    wait_on(2, 1'h1, 2600);
    check(mode_32min, 1'h1);
    u_host.high_impedance_bit = 1'h0;
    bat_low_cmp = 1'h0;
    bus_uvlo_cmp = 1'h1;
    repeat (6) @(negedge ref_clk);
    check(high_impedance, 1'h1);
    bus_uvlo_cmp = 1'h0;
    u_host.sel(1'h1);
    repeat (8) @(negedge ref_clk);
    check({high_impedance, boost_active}, 2'h0);
    conclude();
  end
endmodule
